/* File: common/vdpc_map.svh */
`ifndef VDPC_MAP_SVH
`define VDPC_MAP_SVH
// ==========================================================
// register indices on the serial control bus
`define VDPC_IDX_AUX 8'h0E
`define VDPC_IDX_LUMA 8'h0F
`define VDPC_IDX_GAIN 8'h10
`define VDPC_IDX_OFFS 8'h11
`define VDPC_IDX_COLOR 8'h12
`define VDPC_IDX_DELAY 8'h13
`define VDPC_IDX_DETECT 8'h14
// ==========================================================
// reset values
`define VDPC_RST_AUX 8'h00
`define VDPC_RST_LUMA 8'h00
`define VDPC_RST_GAIN 8'h00
`define VDPC_RST_OFFS 8'h00
`define VDPC_RST_COLOR 8'h08
`define VDPC_RST_DELAY 8'h00
`define VDPC_RST_DETECT 6'h00
`define VDPC_RD_UNMAPPED 8'h00
// ==========================================================
// field positions
`define VDPC_AUX_B_DIR 7
`define VDPC_AUX_B_SEL 6:4
`define VDPC_AUX_A_DIR 3
`define VDPC_AUX_A_SEL 2:0
`define VDPC_LUMA_UNITY 6
`define VDPC_LUMA_FULL 5
`define VDPC_LUMA_SETUP 4
`define VDPC_LUMA_BWR 3
`define VDPC_LUMA_NOTCH 2
`define VDPC_LUMA_PEAK 1:0
`define VDPC_COLOR_HOLD 7
`define VDPC_COLOR_MSYS 6
`define VDPC_COLOR_NSYS 5
`define VDPC_COLOR_BW 4
`define VDPC_COLOR_CORE 3:2
`define VDPC_COLOR_KILL 1:0
`define VDPC_DELAY_TRIM 7:4
`define VDPC_DELAY_PHASE 3:0
// ==========================================================
// chroma codes and steps
`define VDPC_CHROMA_MID 8'h80
`define VDPC_CORE_W1 8'h01
`define VDPC_CORE_W2 8'h03
`define VDPC_CORE_W3 8'h07
`define VDPC_PHASE_STEP_CDEG 2250
`endif

/* File: common/vdpc_pkg.sv */
package vdpc_pkg;
  // ==========================================================
  // mode encodings
  typedef enum logic [2:0] {
    AUXA_OFF = 3'b000, AUXA_BACK_PORCH = 3'b001, AUXA_SYNC_TIP = 3'b010,
    AUXA_BURST = 3'b011, AUXA_BURST_WIDE = 3'b100, AUXA_SYNC_MID = 3'b101,
    AUXA_VBI = 3'b110, AUXA_GP_BIT = 3'b111
  } vdpc_auxa_src_e;
  typedef enum logic [2:0] {
    AUXB_OFF = 3'b000, AUXB_BURST_PHASE = 3'b001, AUXB_DOUBLE = 3'b010,
    AUXB_SYNC_FALL = 3'b011, AUXB_RAW_LINE = 3'b100, AUXB_SLICED = 3'b101,
    AUXB_VSYNC = 3'b110, AUXB_ENC_LOCK = 3'b111
  } vdpc_auxb_src_e;
  typedef enum logic [1:0] {
    KILL_AUTO = 2'b00, KILL_SPARE = 2'b01, KILL_ON = 2'b10,
    KILL_FORCE = 2'b11
  } vdpc_kill_e;
  typedef enum logic [2:0] {
    GAIN_NOMINAL = 3'b000, GAIN_SETUP = 3'b001, GAIN_FULL = 3'b010,
    GAIN_SETUP_FULL = 3'b011, GAIN_UNITY = 3'b100
  } vdpc_gain_e;
  typedef enum logic [2:0] {
    BUS_IDLE = 3'b000, BUS_DEVADDR = 3'b001, BUS_ACK = 3'b010,
    BUS_INDEX = 3'b011, BUS_WRITE = 3'b100, BUS_READ = 3'b101,
    BUS_MACK = 3'b110
  } vdpc_bus_state_e;
  // ==========================================================
  // timing paths; last member is bit 0 = select code 1
  typedef struct packed {
    logic general_purpose_bit;
    logic vbi_window;
    logic sync_midpoint_pulse;
    logic burst_gate_wide;
    logic burst_gate;
    logic sync_tip_gate;
    logic back_porch_gate;
  } vdpc_a_path_s;
  typedef struct packed {
    logic encoder_lock_serial_out;
    logic vertical_sync;
    logic vbi_sliced_line_flag;
    logic vbi_raw_line_flag;
    logic sync_fall_pulse;
    logic double_line_pulse;
    logic sync_burst_phase;
  } vdpc_b_path_s;
  // ==========================================================
  // decoded path settings
  typedef struct packed {
    logic [1:0] peaking_level;
    logic subcarrier_notch_en;
    logic luminance_bw_reduce;
    vdpc_gain_e gain_mode;
    logic signed [7:0] luma_gain_trim;
    logic signed [7:0] luma_offset_trim;
  } vdpc_luma_ctrl_s;
  typedef struct packed {
    vdpc_kill_e color_kill_mode;
    logic [1:0] coring_level;
    logic chroma_bw_sel;
    logic n_system_tracking_sel;
    logic m_system_tracking_sel;
    logic chroma_gain_hold;
    logic [3:0] burst_phase_ref;
    logic signed [4:0] chroma_delay_half;
  } vdpc_chroma_ctrl_s;
endpackage

/* File: design/vdpc_regs.sv */
`timescale 1ns/1ns
`default_nettype none
`include "vdpc_map.svh"
module vdpc_regs
  import vdpc_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h2A // arbitrary bus address
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic aux_a_in,
  output logic aux_a_out,
  output logic aux_a_oe,
  input wire logic aux_b_in,
  output logic aux_b_out,
  output logic aux_b_oe,
  input wire vdpc_a_path_s a_path_int,
  input wire vdpc_b_path_s b_path_int,
  output var vdpc_a_path_s a_path_eff,
  output var vdpc_b_path_s b_path_eff,
  input wire logic fsc_358_det,
  input wire logic secam_det,
  output logic [5:0] detect_ctrl,
  input wire logic [7:0] chroma_in,
  input wire logic burst_ok,
  output logic [7:0] chroma_out,
  output var vdpc_luma_ctrl_s luma_ctrl,
  output var vdpc_chroma_ctrl_s chroma_ctrl
);

  // ==========================================================
  // register file and bus state
  logic [7:0] aux_reg, luma_reg, gain_reg, offs_reg, color_reg, delay_reg;
  logic [5:0] det_reg;
  logic scl_q_reg, sda_q_reg;
  vdpc_bus_state_e st_reg, st_next;
  logic [7:0] shift_reg, shift_next, idx_reg, idx_next;
  logic [3:0] cnt_reg, cnt_next;
  logic oe_reg, oe_next, rw_reg, rw_next;
  logic addr_ph_reg, addr_ph_next, mack_reg, mack_next;

  // ==========================================================
  // decode helpers
  function automatic logic [7:0] core_window(input logic [1:0] lvl);
    unique case (lvl)
      2'h0: core_window = 8'h00;
      2'h1: core_window = `VDPC_CORE_W1;
      2'h2: core_window = `VDPC_CORE_W2;
      2'h3: core_window = `VDPC_CORE_W3;
    endcase
  endfunction
  // delay in half pixel clocks, signed: even codes read as a signed
  // count of halves, odd codes sit one half below their even partner
  function automatic logic signed [4:0] delay_half(input logic [3:0] c);
    delay_half = $signed({c[3], c[3:1], 1'b0}) - $signed({4'h0, c[0]});
  endfunction
  // register read selection
  function automatic logic [7:0] rd_mux(input logic [7:0] i, aux, lum, gn,
    of, col, dl, dt);
    case (i)
      `VDPC_IDX_AUX: rd_mux = aux;
      `VDPC_IDX_LUMA: rd_mux = lum;
      `VDPC_IDX_GAIN: rd_mux = gn;
      `VDPC_IDX_OFFS: rd_mux = of;
      `VDPC_IDX_COLOR: rd_mux = col;
      `VDPC_IDX_DELAY: rd_mux = dl;
      `VDPC_IDX_DETECT: rd_mux = dt;
      default: rd_mux = `VDPC_RD_UNMAPPED;
    endcase
  endfunction

  // ==========================================================
  // serial bus line events
  wire scl_rise = scl_in & ~scl_q_reg;
  wire scl_fall = ~scl_in & scl_q_reg;
  wire bus_start = scl_in & scl_q_reg & sda_q_reg & ~sda_in;
  wire bus_stop = scl_in & scl_q_reg & ~sda_q_reg & sda_in;
  wire byte_done = (cnt_reg == 4'h8);
  wire [7:0] det_byte = {fsc_358_det, secam_det, det_reg};
  wire [7:0] rd_data = rd_mux(idx_reg, aux_reg, luma_reg, gain_reg,
                              offs_reg, color_reg, delay_reg, det_byte);
  wire reg_wr = scl_fall & ~bus_start & ~bus_stop &
                (st_reg == BUS_WRITE) & byte_done;
  // serial bus byte engine
  always_comb begin
    st_next = st_reg;
    shift_next = shift_reg;
    cnt_next = cnt_reg;
    oe_next = oe_reg;
    rw_next = rw_reg;
    addr_ph_next = addr_ph_reg;
    idx_next = idx_reg;
    mack_next = mack_reg;
    if (bus_start) begin
      st_next = BUS_DEVADDR;
      cnt_next = 4'h0;
      oe_next = 1'b0;
    end else if (bus_stop) begin
      st_next = BUS_IDLE;
      oe_next = 1'b0;
    end else if (scl_rise) begin
      unique case (st_reg)
        BUS_DEVADDR, BUS_INDEX, BUS_WRITE: begin
          if (!byte_done) begin
            shift_next = {shift_reg[6:0], sda_in};
            cnt_next = cnt_reg + 4'h1;
          end
        end
        BUS_READ: cnt_next = cnt_reg + 4'h1;
        BUS_MACK: mack_next = ~sda_in;
        default: ;
      endcase
    end else if (scl_fall) begin
      unique case (st_reg)
        BUS_DEVADDR: begin
          if (byte_done && shift_reg[7:1] == DEV_ADDR) begin
            oe_next = 1'b1;
            rw_next = shift_reg[0];
            addr_ph_next = 1'b1;
            st_next = BUS_ACK;
          end else if (byte_done) begin
            st_next = BUS_IDLE;
          end
        end
        BUS_INDEX: begin
          if (byte_done) begin
            idx_next = shift_reg;
            oe_next = 1'b1;
            addr_ph_next = 1'b0;
            st_next = BUS_ACK;
          end
        end
        BUS_WRITE: begin
          if (byte_done) begin
            idx_next = idx_reg + 8'h01;
            oe_next = 1'b1;
            st_next = BUS_ACK;
          end
        end
        BUS_ACK: begin
          cnt_next = 4'h0;
          oe_next = 1'b0;
          if (rw_reg && addr_ph_reg) begin
            shift_next = rd_data;
            oe_next = ~rd_data[7];
            st_next = BUS_READ;
          end else if (addr_ph_reg) begin
            st_next = BUS_INDEX;
          end else begin
            st_next = BUS_WRITE;
          end
        end
        BUS_READ: begin
          if (byte_done) begin
            oe_next = 1'b0;
            idx_next = idx_reg + 8'h01;
            st_next = BUS_MACK;
          end else begin
            oe_next = ~shift_reg[6];
            shift_next = {shift_reg[6:0], 1'b0};
          end
        end
        BUS_MACK: begin
          if (mack_reg) begin
            shift_next = rd_data;
            oe_next = ~rd_data[7];
            cnt_next = 4'h0;
            st_next = BUS_READ;
          end else begin
            st_next = BUS_IDLE;
          end
        end
        default: st_next = BUS_IDLE;
      endcase
    end
  end
  // bus state flops
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
      st_reg <= BUS_IDLE;
      shift_reg <= 8'h00;
      cnt_reg <= 4'h0;
      oe_reg <= 1'b0;
      rw_reg <= 1'b0;
      addr_ph_reg <= 1'b0;
      idx_reg <= 8'h00;
      mack_reg <= 1'b0;
    end else begin
      scl_q_reg <= scl_in;
      sda_q_reg <= sda_in;
      st_reg <= st_next;
      shift_reg <= shift_next;
      cnt_reg <= cnt_next;
      oe_reg <= oe_next;
      rw_reg <= rw_next;
      addr_ph_reg <= addr_ph_next;
      idx_reg <= idx_next;
      mack_reg <= mack_next;
    end
  end

  // ==========================================================
  // register writes from the bus
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      aux_reg <= `VDPC_RST_AUX;
      luma_reg <= `VDPC_RST_LUMA;
      gain_reg <= `VDPC_RST_GAIN;
      offs_reg <= `VDPC_RST_OFFS;
      color_reg <= `VDPC_RST_COLOR;
      delay_reg <= `VDPC_RST_DELAY;
      det_reg <= `VDPC_RST_DETECT;
    end else if (reg_wr) begin
      if (idx_reg == `VDPC_IDX_AUX) aux_reg <= shift_reg;
      if (idx_reg == `VDPC_IDX_LUMA) luma_reg <= shift_reg;
      if (idx_reg == `VDPC_IDX_GAIN) gain_reg <= shift_reg;
      if (idx_reg == `VDPC_IDX_OFFS) offs_reg <= shift_reg;
      if (idx_reg == `VDPC_IDX_COLOR) color_reg <= shift_reg;
      if (idx_reg == `VDPC_IDX_DELAY) delay_reg <= shift_reg;
      if (idx_reg == `VDPC_IDX_DETECT) det_reg <= shift_reg[5:0];
    end
  end

  // ==========================================================
  // auxiliary pin routing
  wire a_dir = aux_reg[`VDPC_AUX_A_DIR];
  wire b_dir = aux_reg[`VDPC_AUX_B_DIR];
  vdpc_auxa_src_e a_sel;
  vdpc_auxb_src_e b_sel;
  assign a_sel = vdpc_auxa_src_e'(aux_reg[`VDPC_AUX_A_SEL]);
  assign b_sel = vdpc_auxb_src_e'(aux_reg[`VDPC_AUX_B_SEL]);
  wire [6:0] a_int = a_path_int;
  wire [6:0] b_int = b_path_int;
  logic [6:0] a_eff_next, b_eff_next;
  // input pin replaces the selected internal gate
  genvar k;
  generate
    for (k = 0; k < 7; k++) begin : g_path
      assign a_eff_next[k] = (!a_dir && a_sel == 3'(k + 1)) ?
                             aux_a_in : a_int[k];
      assign b_eff_next[k] = (!b_dir && b_sel == 3'(k + 1)) ?
                             aux_b_in : b_int[k];
    end
  endgenerate
  // driven pins carry the selected internal signal
  wire a_drv = a_dir && (a_sel != AUXA_OFF);
  wire b_drv = b_dir && (b_sel != AUXB_OFF);
  wire a_out_next = a_drv & a_int[3'(a_sel - 3'h1)];
  // codes 4, 5 and 7 give raw, sliced and encoder lock streams
  wire b_out_next = b_drv & b_int[3'(b_sel - 3'h1)];

  // ==========================================================
  // luma settings
  wire setup_gain_en = luma_reg[`VDPC_LUMA_SETUP];
  wire full_range_gain = luma_reg[`VDPC_LUMA_FULL];
  wire unity_gain = luma_reg[`VDPC_LUMA_UNITY];
  vdpc_gain_e gain_mode;
  assign gain_mode = (setup_gain_en && full_range_gain && unity_gain) ?
                     GAIN_UNITY :
                     vdpc_gain_e'({1'b0, full_range_gain,
                                   setup_gain_en});
  vdpc_luma_ctrl_s luma_next;
  assign luma_next.peaking_level = luma_reg[`VDPC_LUMA_PEAK];
  assign luma_next.subcarrier_notch_en =
    luma_reg[`VDPC_LUMA_NOTCH];
  assign luma_next.luminance_bw_reduce =
    luma_reg[`VDPC_LUMA_BWR];
  assign luma_next.gain_mode = gain_mode;
  assign luma_next.luma_gain_trim = $signed(gain_reg);
  assign luma_next.luma_offset_trim = $signed(offs_reg);

  // ==========================================================
  // chroma settings and sample path
  vdpc_kill_e kill_raw, kill_eff;
  assign kill_raw = vdpc_kill_e'(color_reg[`VDPC_COLOR_KILL]);
  assign kill_eff = (kill_raw == KILL_SPARE) ?
                    KILL_AUTO : kill_raw;
  vdpc_chroma_ctrl_s chroma_next;
  assign chroma_next.color_kill_mode = kill_eff;
  assign chroma_next.coring_level = color_reg[`VDPC_COLOR_CORE];
  assign chroma_next.chroma_bw_sel = color_reg[`VDPC_COLOR_BW];
  assign chroma_next.n_system_tracking_sel =
    color_reg[`VDPC_COLOR_NSYS];
  assign chroma_next.m_system_tracking_sel =
    color_reg[`VDPC_COLOR_MSYS];
  assign chroma_next.chroma_gain_hold =
    color_reg[`VDPC_COLOR_HOLD];
  assign chroma_next.burst_phase_ref =
    delay_reg[`VDPC_DELAY_PHASE];
  assign chroma_next.chroma_delay_half =
    delay_half(delay_reg[`VDPC_DELAY_TRIM]);
  // coring window and kill decision
  wire [7:0] core_w = core_window(color_reg[`VDPC_COLOR_CORE]);
  wire in_core = (color_reg[`VDPC_COLOR_CORE] != 2'h0) &&
                 (chroma_in >= `VDPC_CHROMA_MID - core_w) &&
                 (chroma_in <= `VDPC_CHROMA_MID + core_w);
  wire chroma_mute = (kill_eff == KILL_FORCE) ||
                     (kill_eff == KILL_AUTO && !burst_ok);
  wire [7:0] chroma_next_smp = (chroma_mute || in_core) ?
                               `VDPC_CHROMA_MID : chroma_in;

  // ==========================================================
  // registered outputs
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      aux_a_out <= 1'b0;
      aux_a_oe <= 1'b0;
      aux_b_out <= 1'b0;
      aux_b_oe <= 1'b0;
      a_path_eff <= '0;
      b_path_eff <= '0;
      luma_ctrl <= '0;
      chroma_ctrl <= '0;
      chroma_out <= `VDPC_CHROMA_MID;
      detect_ctrl <= `VDPC_RST_DETECT;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      aux_a_out <= a_out_next;
      aux_a_oe <= a_drv;
      aux_b_out <= b_out_next;
      aux_b_oe <= b_drv;
      a_path_eff <= a_eff_next;
      b_path_eff <= b_eff_next;
      luma_ctrl <= luma_next;
      chroma_ctrl <= chroma_next;
      chroma_out <= chroma_next_smp;
      detect_ctrl <= det_reg;
      sda_out <= 1'b0; // open drain, only pulls low
      sda_oe <= oe_next;
    end
  end
endmodule // vdpc_regs
`default_nettype wire

/* File: bench/vdpc_regs_checker.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// port checker for the pixel control register bank
module vdpc_regs_checker
  import vdpc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic aux_a_oe,
  input wire logic aux_b_oe,
  input wire vdpc_a_path_s a_path_int,
  input wire vdpc_b_path_s b_path_int,
  input wire vdpc_a_path_s a_path_eff,
  input wire vdpc_b_path_s b_path_eff,
  input wire logic [7:0] chroma_in,
  input wire logic burst_ok,
  input wire logic [7:0] chroma_out,
  input wire vdpc_luma_ctrl_s luma_ctrl,
  input wire vdpc_chroma_ctrl_s chroma_ctrl
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // sample inside the coring window around mid code
  function automatic logic in_win(logic [7:0] x, logic [1:0] c);
    logic [7:0] d;
    logic [7:0] w;
    d = (x >= 8'h80) ? x - 8'h80 : 8'h80 - x;
    w = c[1] ? (c[0] ? 8'h07 : 8'h03) : (c[0] ? 8'h01 : 8'h00);
    return (c != 2'h0) && (d <= w);
  endfunction
  // chroma settings unchanged over the last two edges
  sequence s_steady;
    $stable(chroma_ctrl);
  endsequence
  AST_KILL_FORCE: assert property (
    (chroma_ctrl.color_kill_mode == KILL_FORCE) ##1 s_steady
    |-> chroma_out == 8'h80) else $error("chroma not forced");
  AST_KILL_AUTO: assert property (
    (chroma_ctrl.color_kill_mode inside {KILL_AUTO, KILL_SPARE} && !burst_ok)
    ##1 s_steady |-> chroma_out == 8'h80) else $error("auto kill missed");
  AST_CORING: assert property (
    (chroma_ctrl.color_kill_mode == KILL_ON) ##1 s_steady
    |-> chroma_out == (in_win($past(chroma_in), chroma_ctrl.coring_level)
        ? 8'h80 : $past(chroma_in))) else $error("coring result wrong");
  AST_PIN_A_OUT: assert property (
    aux_a_oe |-> a_path_eff == $past(a_path_int))
    else $error("driven pin A altered its path");
  AST_PIN_B_OUT: assert property (
    aux_b_oe |-> b_path_eff == $past(b_path_int))
    else $error("driven pin B altered its path");
  AST_LUMA_HOLD: assert property (
    !$stable(luma_ctrl) |-> !$past(scl_in))
    else $error("luma settings moved outside a bus write");
  AST_GAIN_CODE: assert property (
    luma_ctrl.gain_mode <= GAIN_UNITY) else $error("gain mode out of range");
  AST_DELAY_RANGE: assert property (
    chroma_ctrl.chroma_delay_half >= -5'sd9 &&
    chroma_ctrl.chroma_delay_half <= 5'sd6) else $error("delay out of table");
endmodule // vdpc_regs_checker

bind vdpc_regs vdpc_regs_checker chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .scl_in(scl_in),
  .aux_a_oe(aux_a_oe), .aux_b_oe(aux_b_oe),
  .a_path_int(a_path_int), .b_path_int(b_path_int),
  .a_path_eff(a_path_eff), .b_path_eff(b_path_eff),
  .chroma_in(chroma_in), .burst_ok(burst_ok), .chroma_out(chroma_out),
  .luma_ctrl(luma_ctrl), .chroma_ctrl(chroma_ctrl)
);
`default_nettype wire

/* File: bench/vdpc_host.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// host side of the two-wire control bus
module vdpc_host (
  input wire logic ref_clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // each bus phase lasts four reference cycles
  task automatic wait_clk(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic put_bit(input logic b);
    sda_low = !b;
    wait_clk(4);
    scl = 1'b1;
    wait_clk(4);
    scl = 1'b0;
  endtask
  // line released, sampled mid high phase
  task automatic get_bit(output logic b);
    sda_low = 1'b0;
    wait_clk(4);
    scl = 1'b1;
    wait_clk(2);
    b = sda_line;
    wait_clk(2);
    scl = 1'b0;
  endtask
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(b);
    ack = !b;
  endtask
  // start also serves as repeated start
  task automatic start_cond;
    sda_low = 1'b0;
    wait_clk(4);
    scl = 1'b1;
    wait_clk(4);
    sda_low = 1'b1;
    wait_clk(4);
    scl = 1'b0;
  endtask
  task automatic stop_cond;
    sda_low = 1'b1;
    wait_clk(4);
    scl = 1'b1;
    wait_clk(4);
    sda_low = 1'b0;
    wait_clk(4);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] idx,
                    input logic [7:0] d, output logic ok);
    logic k0, k1, k2;
    start_cond();
    put_byte({a, 1'b0}, k0);
    put_byte(idx, k1);
    put_byte(d, k2);
    stop_cond();
    ok = k0 & k1 & k2;
  endtask
  // index set, repeated start, one byte then no ack
  task automatic rd(input logic [6:0] a, input logic [7:0] idx,
                    output logic [7:0] d, output logic ok);
    logic k0, k1, k2;
    start_cond();
    put_byte({a, 1'b0}, k0);
    put_byte(idx, k1);
    start_cond();
    put_byte({a, 1'b1}, k2);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(1'b1);
    stop_cond();
    ok = k0 & k1 & k2;
  endtask
endmodule // vdpc_host
`default_nettype wire

/* File: bench/tb_video_decoder_pixel_control_regs.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_video_decoder_pixel_control_regs
  import vdpc_pkg::*;
;
  localparam logic [6:0] ADDR = 7'h2A; // arbitrary bus address
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic scl, sda_low, sda_out, sda_oe, aux_a_out, aux_a_oe, aux_b_out;
  logic aux_b_oe, aux_a_in, aux_b_in, fsc_det, secam_det, burst_ok;
  logic [5:0] detect_ctrl;
  logic [7:0] chroma_in, chroma_out;
  vdpc_a_path_s a_int, a_eff;
  vdpc_b_path_s b_int, b_eff;
  vdpc_luma_ctrl_s luma_ctrl;
  vdpc_chroma_ctrl_s chroma_ctrl;
  int fail_count = 0;
  int n_checks = 0;
  // pulled-up data line
  wire logic sda_line = !(sda_low || (sda_oe && !sda_out));
  always #20 ref_clk = ~ref_clk;
  // ==========================================================
  // design, host model
  vdpc_regs uut (
    .ref_clk(ref_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .aux_a_in(aux_a_in),
    .aux_a_out(aux_a_out), .aux_a_oe(aux_a_oe), .aux_b_in(aux_b_in),
    .aux_b_out(aux_b_out), .aux_b_oe(aux_b_oe), .a_path_int(a_int),
    .b_path_int(b_int), .a_path_eff(a_eff), .b_path_eff(b_eff),
    .fsc_358_det(fsc_det), .secam_det(secam_det), .detect_ctrl(detect_ctrl),
    .chroma_in(chroma_in), .burst_ok(burst_ok), .chroma_out(chroma_out),
    .luma_ctrl(luma_ctrl), .chroma_ctrl(chroma_ctrl)
  );
  vdpc_host host (
    .ref_clk(ref_clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low)
  );
  // ==========================================================
  // tasks
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic ok;
    host.wr(ADDR, idx, d, ok);
    chk8({7'h0, ok}, 8'h01);
  endtask
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    host.rd(ADDR, idx, d, ok);
    chk8({7'h0, ok}, 8'h01);
    chk8(d, exp);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ==========================================================
  // watchdog
  initial begin
    repeat (60000) @(posedge ref_clk);
    fail_count++;
    end_sim();
  end
  // ==========================================================
  // main sequence
  initial begin : main
    logic ok;
    logic [2:0] sb;
    logic [6:0] oa, ob;
    logic [7:0] exp;
    logic [4:0] dl;
    logic [7:0] w_tab [4];
    int dl_tab [16];
    w_tab = '{8'h00, 8'h01, 8'h03, 8'h07};
    dl_tab = '{0, -1, 2, 1, 4, 3, 6, 5, -8, -9, -6, -7, -4, -5, -2, -3};
    {aux_a_in, aux_b_in, fsc_det, secam_det, burst_ok} = 5'b00100;
    {a_int, b_int} = 14'h0;
    chroma_in = 8'h40;
    tick(10);
    rst_n = 1'b1;
    tick(2);
    // reset values, unmapped index, foreign address
    chk8(chroma_out, 8'h80);
    for (int i = 0; i < 6; i++) begin
      rd_chk(8'(8'h0E + i), (i == 4) ? 8'h08 : 8'h00);
    end
    rd_chk(8'h20, 8'h00);
    host.wr(7'h15, 8'h10, 8'h55, ok);
    chk8({7'h0, ok}, 8'h00);
    wr(8'h14, 8'hFF);
    rd_chk(8'h14, 8'hBF);
    chk8({2'b0, detect_ctrl}, 8'h3F);
    wr(8'h10, 8'h80);
    wr(8'h11, 8'h7F);
    rd_chk(8'h10, 8'h80);
    chk8(luma_ctrl.luma_gain_trim, 8'h80);
    chk8(luma_ctrl.luma_offset_trim, 8'h7F);
    $display("test registers done");
    // pin routing, both directions, B code is 8 minus the A code
    for (int s = 1; s < 8; s++) begin
      for (int d = 0; d < 2; d++) begin
        sb = 3'(8 - s);
        oa = 7'(1 << (s - 1));
        ob = 7'(1 << (7 - s));
        a_int = d ? oa : 7'h0;
        b_int = d ? ob : 7'h0;
        aux_a_in = !d;
        aux_b_in = !d;
        wr(8'h0E, {d[0], sb, d[0], 3'(s)});
        chk8({7'h0, aux_a_oe}, {7'h0, d[0]});
        chk8({7'h0, aux_b_oe}, {7'h0, d[0]});
        chk8({1'b0, a_eff}, {1'b0, oa});
        chk8({1'b0, b_eff}, {1'b0, ob});
        chk8({6'h0, aux_a_out, aux_b_out}, {6'h0, d[0], d[0]});
      end
    end
    wr(8'h0E, 8'h88);
    chk8({6'h0, aux_a_oe, aux_b_oe}, 8'h00);
    $display("test pins done");
    // luma settings, every gain bit mix
    for (int g = 0; g < 8; g++) begin
      wr(8'h0F, {1'b0, 3'(g), g[1], g[0], 2'(g)});
      exp = (g == 7) ? 8'(GAIN_UNITY) : 8'(g & 3);
      chk8(8'(luma_ctrl.gain_mode), exp);
      chk8({6'h0, luma_ctrl.peaking_level}, 8'(g & 3));
      chk8({7'h0, luma_ctrl.subcarrier_notch_en}, 8'(g & 1));
      chk8({7'h0, luma_ctrl.luminance_bw_reduce}, 8'(g[1]));
    end
    $display("test luma done");
    // chroma mode bits
    for (int c = 0; c < 16; c++) begin
      wr(8'h12, {4'(c), 4'h8});
      chk8({4'h0, chroma_ctrl.chroma_gain_hold,
        chroma_ctrl.m_system_tracking_sel, chroma_ctrl.n_system_tracking_sel,
        chroma_ctrl.chroma_bw_sel}, 8'(c));
    end
    // kill modes against burst presence
    for (int k = 0; k < 4; k++) begin
      wr(8'h12, {6'h0, 2'(k)});
      for (int b = 0; b < 2; b++) begin
        burst_ok = b[0];
        tick(2);
        exp = (k == 2 || (k < 2 && b == 1)) ? 8'h40 : 8'h80;
        chk8(chroma_out, exp);
      end
    end
    // coring window edges
    for (int c = 0; c < 4; c++) begin
      wr(8'h12, {4'h0, 2'(c), 2'h2});
      for (int j = 0; j < 3; j++) begin
        chroma_in = (j == 0) ? 8'h80 + w_tab[c] :
                    (j == 1) ? 8'h80 - w_tab[c] : 8'h81 + w_tab[c];
        tick(2);
        chk8(chroma_out, (j < 2) ? 8'h80 : chroma_in);
      end
    end
    $display("test chroma done");
    // delay trim and burst phase codes
    for (int i = 0; i < 16; i++) begin
      wr(8'h13, {4'(i), 4'(i)});
      dl = 5'(dl_tab[i]);
      chk8({3'h0, chroma_ctrl.chroma_delay_half}, {3'h0, dl});
      chk8({4'h0, chroma_ctrl.burst_phase_ref}, 8'(i));
    end
    $display("test delay done");
    end_sim();
  end
endmodule // tb_video_decoder_pixel_control_regs
`default_nettype wire
